// ==== hdl/mmtc_map.svh ====
`ifndef MMTC_MAP_SVH
`define MMTC_MAP_SVH
// Register word addresses (index); byte address is four times the index.
`define MMTC_IDX_MODE       6'h18
`define MMTC_IDX_SOFTRST    6'h19
`define MMTC_IDX_WPROT      6'h1a
`define MMTC_IDX_TCTRL      6'h1b
`define MMTC_IDX_IRQ_STAT   6'h20
`define MMTC_IDX_IRQ_EN     6'h21
`define MMTC_IDX_IRQ_CLR    6'h22
`define MMTC_IDX_STATUS     6'h23
`define MMTC_IDX_TEMP_IN    6'h24
// Reset values, writable masks and keys.
`define MMTC_MODE_RST       16'h0000
`define MMTC_MODE_MASK      16'h1373
`define MMTC_TCTRL_RST      16'h07ff
`define MMTC_TCTRL_MASK     16'hffff
`define MMTC_WPROT_RST      8'h00
`define MMTC_WPROT_KEY      8'h55
`define MMTC_SOFTRST_KEY    24'h5a5a5a
// Field positions.
`define MMTC_CUR_FSEL_LSB   0
`define MMTC_VOL_FSEL_LSB   4
`define MMTC_FAST_SRC_BIT   6
`define MMTC_RMS_PER_BIT    8
`define MMTC_AC_FREQ_BIT    9
`define MMTC_PULSE_FN_BIT   12
`define MMTC_ALARM_SRC_BIT  14
`define MMTC_SENSOR_LSB     12
`define MMTC_THRESH_MSB     9
// Interrupt bits.
`define MMTC_IRQ_TEMP       0
`define MMTC_IRQ_RMS        1
`define MMTC_IRQ_WERR       2
`define MMTC_IRQ_W          3
// Timing.
`define MMTC_CLK_HZ         40000000
`define MMTC_RMS_SHORT_MS   400
`define MMTC_RMS_LONG_MS    800
`endif

// ==== hdl/mmtc_pkg.sv ====
package mmtc_pkg;
  typedef enum logic [1:0] {MMTC_HPF_A, MMTC_HPF_B, MMTC_LPF, MMTC_FULL} mmtc_fsel_t;
  typedef enum logic [1:0] {MMTC_PATH_HPF, MMTC_PATH_LPF, MMTC_PATH_FULL} mmtc_path_t;
  typedef enum logic [1:0] {MMTC_SENS_AUTO, MMTC_SENS_INT, MMTC_SENS_EXT} mmtc_sens_t;
  typedef enum logic {MMTC_BUS_IDLE, MMTC_BUS_ACK} mmtc_bus_t;
endpackage

// ==== hdl/mmtc_rms_timer.sv ====
`timescale 1ns/100ps
`include "mmtc_map.svh"
module mmtc_rms_timer
  import mmtc_pkg::*;
#(
  parameter int unsigned SHORT_CYC = `MMTC_CLK_HZ / 1000 * `MMTC_RMS_SHORT_MS,
  parameter int unsigned LONG_CYC  = `MMTC_CLK_HZ / 1000 * `MMTC_RMS_LONG_MS
)(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic restart_i,
  input  wire logic long_i,
  output logic      tick_o
);
  typedef struct packed
  {
    logic [31:0] cnt;
    logic        tick;
  } mmtc_tmr_t;
  mmtc_tmr_t st_reg;
  mmtc_tmr_t st_next;
  logic [31:0] limit;

  always_comb
  begin
    limit = long_i ? LONG_CYC - 32'd1 : SHORT_CYC - 32'd1;
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (restart_i)
    begin
      st_next.cnt = 32'h0;
    end
    else if (st_reg.cnt >= limit)
    begin
      st_next.cnt = 32'h0;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_reg <= '0;
    else if (ce_i)
      st_reg <= st_next;
  end

  assign tick_o = st_reg.tick;
endmodule

// ==== hdl/mmtc_alarm.sv ====
`timescale 1ns/100ps
`include "mmtc_map.svh"
module mmtc_alarm
  import mmtc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic [9:0] ext_temp_i,
  input  wire logic [9:0] threshold_i,
  input  wire logic       src_overcur_i,
  input  wire logic       overcur_i,
  input  wire logic       leak_i,
  output logic            alarm_o
);
  typedef struct packed
  {
    logic alarm;
  } mmtc_alm_t;
  mmtc_alm_t st_reg;
  mmtc_alm_t st_next;

  always_comb
  begin
    st_next = st_reg;
    if (src_overcur_i)
      st_next.alarm = overcur_i | leak_i;
    else
      st_next.alarm = (ext_temp_i >= threshold_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_reg <= '0;
    else if (ce_i)
      st_reg <= st_next;
  end

  assign alarm_o = st_reg.alarm;
endmodule

// ==== hdl/mmtc_regs.sv ====
`timescale 1ns/100ps
`include "mmtc_map.svh"
//////////////////////////////////////////////////////////////////////////////
module mmtc_regs
  import mmtc_pkg::*;
#(
  // Refresh periods in clock cycles; a bench may shorten them to reach several ticks.
  parameter int unsigned RMS_SHORT_CYC = `MMTC_CLK_HZ / 1000 * `MMTC_RMS_SHORT_MS,
  parameter int unsigned RMS_LONG_CYC  = `MMTC_CLK_HZ / 1000 * `MMTC_RMS_LONG_MS
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             err_o,
  input  wire logic [9:0]  external_temperature_result_i,
  input  wire logic        overcur_i,
  input  wire logic        leak_i,
  input  wire logic        energy_pulse_i,
  output logic             energy_pulse_output_o,
  output mmtc_pkg::mmtc_path_t current_path_o,
  output mmtc_pkg::mmtc_path_t voltage_path_o,
  output logic             fast_rms_after_hpf_o,
  output logic             ac_freq_60_o,
  output mmtc_pkg::mmtc_sens_t sensor_select_o,
  output logic             temp_off_o,
  output logic [1:0]       temp_interval_o,
  output logic             rms_update_o,
  output logic             irq_o
);
  typedef struct packed
  {
    logic [15:0] mode;
    logic [15:0] tctrl;
    logic [7:0]  wprot;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_en;
    logic [31:0] rdata;
    logic        ack;
    logic        err;
    logic        alarm_d;
    logic        pulse_out;
    mmtc_path_t  cur_path;
    mmtc_path_t  vol_path;
  } mmtc_st_t;
  mmtc_st_t st_reg;
  mmtc_st_t st_next;

  logic        rms_tick;
  logic        alarm;
  logic [5:0]  idx;
  logic        req;
  logic        wr;
  logic [31:0] wmask;
  logic [3:0]  ev;

  function automatic mmtc_path_t decode_path(input logic [1:0] f);
    mmtc_path_t p;
    p = MMTC_PATH_HPF;
    case (mmtc_fsel_t'(f))
      MMTC_LPF:  p = MMTC_PATH_LPF;
      MMTC_FULL: p = MMTC_PATH_FULL;
      default:   p = MMTC_PATH_HPF;
    endcase
    return p;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [31:0] m, input logic [15:0] keep);
    return ((old & ~m[15:0]) | (d[15:0] & m[15:0])) & keep;
  endfunction

  mmtc_rms_timer
  #(
    .SHORT_CYC (RMS_SHORT_CYC),
    .LONG_CYC  (RMS_LONG_CYC)
  )
  u_rms_timer
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .restart_i (wr && idx == `MMTC_IDX_MODE),
    .long_i    (st_reg.mode[`MMTC_RMS_PER_BIT]),
    .tick_o    (rms_tick)
  );

  mmtc_alarm u_alarm
  (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .ce_i          (ce_i),
    .ext_temp_i    (external_temperature_result_i),
    .threshold_i   (st_reg.tctrl[`MMTC_THRESH_MSB:0]),
    .src_overcur_i (st_reg.tctrl[`MMTC_ALARM_SRC_BIT]),
    .overcur_i     (overcur_i),
    .leak_i        (leak_i),
    .alarm_o       (alarm)
  );

  assign idx = adr_i[7:2];
  assign req = cyc_i && stb_i && !st_reg.ack && !st_reg.err;
  assign wr  = req && we_i;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

  always_comb
  begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.err = 1'b0;
    ev = '0;
    ev[`MMTC_IRQ_TEMP] = alarm && !st_reg.alarm_d;
    ev[`MMTC_IRQ_RMS] = rms_tick;
    st_next.alarm_d = alarm;
    // Pulse pin carries energy pulses until switched to alarm duty.
    st_next.pulse_out = st_reg.mode[`MMTC_PULSE_FN_BIT] ? alarm : energy_pulse_i;
    st_next.cur_path = decode_path(st_reg.mode[`MMTC_CUR_FSEL_LSB +: 2]);
    st_next.vol_path = decode_path(st_reg.mode[`MMTC_VOL_FSEL_LSB +: 2]);
    if (req)
    begin
      st_next.rdata = 32'h0;
      st_next.ack = 1'b1;
      case (idx)
        `MMTC_IDX_MODE:
        begin
          st_next.rdata = {16'h0, st_reg.mode};
          if (we_i && st_reg.wprot == `MMTC_WPROT_KEY)
            st_next.mode = merge16(st_reg.mode, dat_i, wmask, `MMTC_MODE_MASK);
          else if (we_i)
            ev[`MMTC_IRQ_WERR] = 1'b1;
        end
        `MMTC_IDX_TCTRL:
        begin
          st_next.rdata = {16'h0, st_reg.tctrl};
          if (we_i && st_reg.wprot == `MMTC_WPROT_KEY)
            st_next.tctrl = merge16(st_reg.tctrl, dat_i, wmask, `MMTC_TCTRL_MASK);
          else if (we_i)
            ev[`MMTC_IRQ_WERR] = 1'b1;
        end
        `MMTC_IDX_WPROT:
        begin
          st_next.rdata = {24'h0, st_reg.wprot};
          if (we_i && sel_i[0])
            st_next.wprot = dat_i[7:0];
        end
        `MMTC_IDX_SOFTRST:
        begin
          // Reads as zero; the key itself is never stored.
          if (we_i && sel_i[2:0] == 3'h7 && dat_i[23:0] == `MMTC_SOFTRST_KEY)
          begin
            st_next.mode  = `MMTC_MODE_RST;
            st_next.tctrl = `MMTC_TCTRL_RST;
            st_next.wprot = `MMTC_WPROT_RST;
          end
        end
        `MMTC_IDX_IRQ_STAT:
          st_next.rdata = {28'h0, st_reg.irq_stat};
        `MMTC_IDX_IRQ_EN:
        begin
          st_next.rdata = {28'h0, st_reg.irq_en};
          if (we_i && sel_i[0])
            st_next.irq_en = dat_i[3:0];
        end
        `MMTC_IDX_IRQ_CLR:
        begin
          if (we_i && sel_i[0])
            st_next.irq_stat = st_reg.irq_stat & ~dat_i[3:0];
        end
        `MMTC_IDX_STATUS:
          st_next.rdata = {29'h0, st_reg.pulse_out, overcur_i | leak_i, alarm};
        `MMTC_IDX_TEMP_IN:
          st_next.rdata = {22'h0, external_temperature_result_i};
        default:
        begin
          st_next.ack = 1'b0;
          st_next.err = 1'b1;
        end
      endcase
    end
    // Set wins over a clear in the same cycle.
    st_next.irq_stat = st_next.irq_stat | ev;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg          <= '0;
      st_reg.mode     <= `MMTC_MODE_RST;
      st_reg.tctrl    <= `MMTC_TCTRL_RST;
      st_reg.wprot    <= `MMTC_WPROT_RST;
    end
    else if (ce_i)
    begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign dat_o                 = st_reg.rdata;
  assign ack_o                 = st_reg.ack;
  assign err_o                 = st_reg.err;
  assign energy_pulse_output_o = st_reg.pulse_out;
  assign current_path_o        = st_reg.cur_path;
  assign voltage_path_o        = st_reg.vol_path;
  assign fast_rms_after_hpf_o  = st_reg.mode[`MMTC_FAST_SRC_BIT];
  assign ac_freq_60_o          = st_reg.mode[`MMTC_AC_FREQ_BIT];
  // Codes 00 and 01 both mean automatic selection.
  assign sensor_select_o = st_reg.tctrl[`MMTC_SENSOR_LSB + 1]
                         ? (st_reg.tctrl[`MMTC_SENSOR_LSB] ? MMTC_SENS_EXT : MMTC_SENS_INT)
                         : MMTC_SENS_AUTO;
  assign temp_off_o            = st_reg.tctrl[15];
  assign temp_interval_o       = st_reg.tctrl[11:10];
  assign rms_update_o          = rms_tick;
  assign irq_o                 = |(st_reg.irq_stat & st_reg.irq_en);
endmodule

// ==== testbench/mmtc_host.sv ====
`timescale 1ns/100ps
module mmtc_host
(
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  initial
  begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end

  // The request stands unchanged until ack or err is sampled; the bench timeout ends a hang.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    do @(posedge clk_i); while (!(ack_i || err_i));
    q = dat_i;
    e = err_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
  endtask
endmodule

// ==== testbench/mmtc_regs_sva.sv ====
`timescale 1ns/100ps
module mmtc_regs_sva
  import mmtc_pkg::*;
(
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 ce_i,
  input wire logic                 cyc_i,
  input wire logic                 stb_i,
  input wire logic                 ack_o,
  input wire logic                 err_o,
  input wire logic                 rms_update_o,
  input wire mmtc_pkg::mmtc_path_t current_path_o,
  input wire mmtc_pkg::mmtc_path_t voltage_path_o,
  input wire mmtc_pkg::mmtc_sens_t sensor_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_one_cycle: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  a_err_one_cycle: assert property (err_o |=> !err_o)
    else $error("err held too long");
  a_answer_next: assert property
    ((cyc_i && stb_i && ce_i && !ack_o && !err_o) |=> (ack_o || err_o))
    else $error("no answer one cycle after request");
  a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_ack_err_apart: assert property (!(ack_o && err_o))
    else $error("ack and err together");
  a_cur_path_legal: assert property (current_path_o != 2'h3)
    else $error("illegal current path");
  a_volt_path_legal: assert property (voltage_path_o != 2'h3)
    else $error("illegal voltage path");
  a_sensor_legal: assert property (sensor_select_o != 2'h3)
    else $error("illegal sensor select");
  a_rms_tick_pulse: assert property (rms_update_o |=> !rms_update_o)
    else $error("rms tick too long");
endmodule

bind mmtc_regs mmtc_regs_sva chk_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .err_o(err_o), .rms_update_o(rms_update_o),
  .current_path_o(current_path_o), .voltage_path_o(voltage_path_o),
  .sensor_select_o(sensor_select_o));

// ==== testbench/meter_mode_temp_control_regs_tb_top.sv ====
`timescale 1ns/100ps
module meter_mode_temp_control_regs_tb_top;
  import mmtc_pkg::*;
  typedef struct packed {logic [15:0] w; logic [15:0] r; logic [3:0] p;} mmtc_row_t;
  logic        clk_i, rst_i, ce_i, cyc, stb, we, ack, err, ovc, leak, pin, pout;
  logic        fast, acf, toff, rupd, irq, e;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic [9:0]  ext;
  logic [1:0]  tint;
  mmtc_path_t  cpath, vpath;
  mmtc_sens_t  sens;
  int          err_total, cmp_count, tcnt;
  // Mode written, mode read back, {current path, voltage path} expected.
  mmtc_row_t   rows [6] = '{36'h0000_0000_0, 36'h0001_0001_0, 36'h0022_0022_5,
                            36'h1373_1373_a, 36'hffff_1373_a, 36'h0013_0013_8};

  mmtc_host host_u (.clk_i(clk_i), .ack_i(ack), .err_i(err), .dat_i(rdat), .cyc_o(cyc),
    .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  mmtc_regs #(.RMS_SHORT_CYC(10), .RMS_LONG_CYC(20)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .err_o(err),
    .external_temperature_result_i(ext), .overcur_i(ovc), .leak_i(leak), .energy_pulse_i(pin),
    .energy_pulse_output_o(pout), .current_path_o(cpath), .voltage_path_o(vpath),
    .fast_rms_after_hpf_o(fast), .ac_freq_60_o(acf), .sensor_select_o(sens),
    .temp_off_o(toff), .temp_interval_o(tint), .rms_update_o(rupd), .irq_o(irq));

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic summarize;
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Two idle cycles after a write let registered outputs settle before they are compared.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q, e);
    repeat (2) @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a);
    host_u.xfer(1'b0, a, 32'h0, q, e);
  endtask

  // Cycles between two refresh ticks; a pause of the clock enable must stretch the gap.
  task automatic rms_gap(input int hold, input int exp);
    int n;
    n = hold;
    do @(posedge clk_i); while (!rupd);
    if (hold > 0)
    begin
      ce_i <= 1'b0;
      repeat (hold) @(posedge clk_i);
      ce_i <= 1'b1;
    end
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (!rupd && n < 100);
    chk(n, exp);
  endtask

  always @(posedge clk_i)
  begin
    tcnt++;
    if (tcnt == 20000)
    begin
      err_total++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {err_total, cmp_count, tcnt} = '0;
    {rst_i, ce_i, ovc, leak, pin, ext} = {1'b1, 1'b1, 3'h0, 10'h0};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h60); chk(q, 32'h0);
    rd(8'h6c); chk(q, 32'h07ff);
    chk({toff, tint}, 3'h1);
    chk(sens, MMTC_SENS_AUTO);
    wr(8'h68, 32'h55);
    foreach (rows[i])
    begin
      wr(8'h60, rows[i].w);
      rd(8'h60); chk(q, rows[i].r);
      chk({cpath, vpath}, rows[i].p);
      chk(fast, rows[i].r[6]);
      chk(acf, rows[i].r[9]);
    end
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h6c, 32'(c) << 12);
      chk(sens, (c < 2) ? 0 : c - 1);
    end
    wr(8'h6c, 32'h0010);
    ext <= 10'd15;
    wr(8'h60, 32'h1000);
    rd(8'h8c); chk(q, 32'h0);
    ext <= 10'd16;
    wr(8'h60, 32'h1000);
    rd(8'h8c); chk(q, 32'h5);
    chk(pout, 1'b1);
    wr(8'h6c, 32'h4010);
    chk(pout, 1'b0);
    ovc <= 1'b1;
    wr(8'h68, 32'h00);
    chk(pout, 1'b1);
    ovc <= 1'b0;
    leak <= 1'b1;
    rd(8'h8c); chk(q, 32'h7);
    leak <= 1'b0;
    wr(8'h60, 32'h0022);
    rd(8'h60); chk(q, 32'h1000);
    rd(8'h80); chk(q, 32'h7);
    chk(irq, 1'b0);
    wr(8'h84, 32'h4);
    chk(irq, 1'b1);
    wr(8'h88, 32'h4);
    chk(irq, 1'b0);
    wr(8'h68, 32'h55);
    wr(8'h64, 32'h5a5a5a);
    rd(8'h60); chk(q, 32'h0);
    rd(8'h6c); chk(q, 32'h07ff);
    pin <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(pout, 1'b1);
    pin <= 1'b0;
    wr(8'h60, 32'h0022);
    rd(8'h60); chk(q, 32'h0);
    rms_gap(0, 10);
    rms_gap(5, 15);
    wr(8'h68, 32'h55);
    wr(8'h60, 32'h0100);
    rms_gap(0, 20);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h60); chk(q, 32'h0);
    rd(8'h68); chk(q, 32'h0);
    rd(8'h84); chk(q, 32'h0);
    rd(8'hfc); chk(e, 1'b1);
    summarize();
  end
endmodule
